//--- logic/ddac_pkg.sv
// package: field positions, codes, widths and types for the dual converter command decoder
package ddac_pkg;
  localparam int          WORD_BITS = 16;
  localparam int          CODE_BITS = 12;
  localparam int          CNT_BITS  = 5;
  localparam logic [4:0]  FRAME_LEN = 5'h10;
  // field positions in the serial word
  localparam int          POS_CTRL_HI = 15;
  localparam int          POS_CTRL_LO = 14;
  localparam int          POS_CHSEL   = 13;
  localparam int          POS_PDFLAG  = 12;
  localparam int          POS_TERM_HI = 11;
  localparam int          POS_TERM_LO = 10;
  localparam logic [11:0] ZERO_SCALE  = 12'h000;
  // power-down target codes (ctrl_bit_hi, ctrl_bit_lo)
  localparam logic [1:0]  PD_TGT_A    = 2'h1;
  localparam logic [1:0]  PD_TGT_B    = 2'h2;

  // output termination while powered down
  typedef enum logic [1:0] {
    DDAC_TERM_ACTIVE = 2'h0,
    DDAC_TERM_FLOAT  = 2'h1,
    DDAC_TERM_1K     = 2'h2,
    DDAC_TERM_100K   = 2'h3
  } ddac_term_t;

  // per-channel state presented at the outputs
  typedef struct packed {
    logic [11:0] code;
    ddac_term_t  term;
  } ddac_chan_t;

  // decode of the termination field
  function automatic ddac_term_t term_of(input logic [1:0] sel);
    case (sel)
      2'h1:    term_of = DDAC_TERM_1K;
      2'h2:    term_of = DDAC_TERM_100K;
      default: term_of = DDAC_TERM_FLOAT;
    endcase
  endfunction
endpackage

//--- logic/ddac_sync2.sv
// two-flop synchroniser for one level
`timescale 1ns/100ps
module ddac_sync2 (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  // first stage read only by the second
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // ddac_sync2

//--- logic/ddac_decoder.sv
// serial command decoder and register update for a dual 12-bit converter
`timescale 1ns/100ps
module ddac_decoder (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 async_clear_n,
  input  wire logic                 sclk,
  input  wire logic                 sync_n,
  input  wire logic                 serial_in,
  input  wire logic                 chain_enable,
  output ddac_pkg::ddac_chan_t      chan_a,
  output ddac_pkg::ddac_chan_t      chan_b,
  output logic                      serial_out,
  output logic                      serial_out_oe
);
  logic                 sclk_s, sync_s, din_s, chain_s;
  logic                 frame_s;
  logic                 sclk_q, sync_q;
  logic [15:0]          shift_q, shift_d;
  logic [4:0]           cnt_q;
  logic                 done_q;
  logic [11:0]          in_a_q, in_b_q;
  logic [15:0]          word;
  logic                 rst_n;

  // clear pin acts like reset, asynchronously
  assign rst_n = resetn & async_clear_n;

  // pin synchronisers
  ddac_sync2 u_s0 (.sys_clk(sys_clk), .resetn(rst_n), .async_in(sclk),     .sync_out(sclk_s));
  // frame sync enters inverted so a cleared synchroniser reads as idle, no false rise
  ddac_sync2 u_s1 (.sys_clk(sys_clk), .resetn(rst_n), .async_in(~sync_n),  .sync_out(frame_s));
  assign sync_s = ~frame_s;
  ddac_sync2 u_s2 (.sys_clk(sys_clk), .resetn(rst_n), .async_in(serial_in),.sync_out(din_s));
  ddac_sync2 u_s3 (.sys_clk(sys_clk), .resetn(rst_n), .async_in(chain_enable),
                   .sync_out(chain_s));

  // edge detection on synchronised pins
  wire sclk_fall = sclk_q & ~sclk_s;
  wire sync_rise = ~sync_q & sync_s;
  wire bit_take  = sclk_fall & ~sync_s;
  assign shift_d = {shift_q[14:0], din_s};

  // execution strobes
  // immediate execute at sixteenth bit
  wire exec_now   = bit_take & ~chain_s & (cnt_q == ddac_pkg::FRAME_LEN - 5'h1) & ~done_q;
  wire exec_chain = sync_rise & chain_s & (cnt_q >= ddac_pkg::FRAME_LEN);
  wire exec       = exec_now | exec_chain;
  assign word     = exec_now ? shift_d : shift_q;

  // command field decode
  wire       c_hi  = word[ddac_pkg::POS_CTRL_HI];
  wire       c_lo  = word[ddac_pkg::POS_CTRL_LO];
  wire       c_sel = word[ddac_pkg::POS_CHSEL];
  wire       pd    = word[ddac_pkg::POS_PDFLAG];
  wire [11:0] data = word[11:0];
  wire [1:0] tgt   = {c_hi, c_lo};
  wire st_a  = exec & ~pd & (tgt == 2'h0) & ~c_sel;
  wire st_b  = exec & ~pd & (tgt == 2'h0) &  c_sel;
  wire wr_a  = exec & ~pd & ((tgt == 2'h1) | (tgt == 2'h3 & ~c_sel));
  wire wr_b  = exec & ~pd & ((tgt == 2'h2) | (tgt == 2'h3 & ~c_sel));
  wire cp_a  = exec & ~pd & ((tgt == 2'h2 & c_sel) | (tgt == 2'h3 & c_sel));
  wire cp_b  = exec & ~pd & ((tgt == 2'h1 & c_sel) | (tgt == 2'h3 & c_sel));
  wire pd_a  = exec & pd & (tgt != ddac_pkg::PD_TGT_B);
  wire pd_b  = exec & pd & (tgt != ddac_pkg::PD_TGT_A);
  wire [1:0] tsel = {word[ddac_pkg::POS_TERM_HI], word[ddac_pkg::POS_TERM_LO]};
  wire ddac_pkg::ddac_term_t pd_term = ddac_pkg::term_of(tsel);

  // pin edge history and frame shifter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q  <= 1'b0;
      sync_q  <= 1'b1;
      shift_q <= 16'h0000;
    end else begin
      sclk_q  <= sclk_s;
      sync_q  <= sync_s;
      if (bit_take) shift_q <= shift_d;
    end
  end

  // bit counter; saturates, restarts each frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 5'h00;
      done_q <= 1'b0;
    end else if (sync_s) begin
      cnt_q  <= 5'h00;
      done_q <= 1'b0;
    end else if (bit_take) begin
      if (cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h01;
      if (exec_now) done_q <= 1'b1;
    end
  end

  // input registers
  // zero scale after reset or clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_a_q <= ddac_pkg::ZERO_SCALE;
      in_b_q <= ddac_pkg::ZERO_SCALE;
    end else begin
      if (st_a | wr_a) in_a_q <= data;
      if (st_b | wr_b) in_b_q <= data;
    end
  end

  // converter registers and power state
  // code held as unsigned binary
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_a <= '{code: ddac_pkg::ZERO_SCALE, term: ddac_pkg::DDAC_TERM_ACTIVE};
      chan_b <= '{code: ddac_pkg::ZERO_SCALE, term: ddac_pkg::DDAC_TERM_ACTIVE};
    end else begin
      if (wr_a) chan_a.code <= data;
      else if (cp_a) chan_a.code <= in_a_q;
      if (wr_b) chan_b.code <= data;
      else if (cp_b) chan_b.code <= in_b_q;
      if (pd_a) chan_a.term <= pd_term;
      else if (wr_a | cp_a) chan_a.term <= ddac_pkg::DDAC_TERM_ACTIVE;
      if (pd_b) chan_b.term <= pd_term;
      else if (wr_b | cp_b) chan_b.term <= ddac_pkg::DDAC_TERM_ACTIVE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= chain_s & ~sync_s;
      if (bit_take) serial_out <= shift_d[15]; // next stage takes it at the following fall
    end
  end

  // checks
  // last bit of a normal frame taken this cycle
  sequence frame_end_s;
    bit_take & ~chain_s & (cnt_q == ddac_pkg::FRAME_LEN - 5'h1) & ~done_q;
  endsequence

  // chained frame closed by a sync rise after enough bits
  sequence chain_end_s;
    sync_rise & chain_s & (cnt_q >= ddac_pkg::FRAME_LEN);
  endsequence

  store_a_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_end_s ##0 ({c_hi, c_lo, c_sel, pd} == 4'h0)
    |=> (in_a_q == $past(shift_d[11:0])) && $stable(chan_a) && $stable(chan_b))
    else $error("store to A wrong");
  store_b_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (exec & ~pd & (tgt == 2'h0) & c_sel)
    |=> (in_b_q == $past(data)) && $stable(in_a_q) && $stable(chan_a) && $stable(chan_b))
    else $error("store to B wrong");
  write_a_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_a |=> (chan_a.code == $past(data)) && (in_a_q == $past(data)))
    else $error("write to A wrong");
  copy_b_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (exec & ~pd & tgt == 2'h1 & c_sel) |=> chan_b.code == $past(in_b_q))
    else $error("copy to B wrong");
  write_b_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_b |=> (chan_b.code == $past(data)) && (in_b_q == $past(data)))
    else $error("write to B wrong");
  copy_a_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (exec & ~pd & tgt == 2'h2 & c_sel) |=> chan_a.code == $past(in_a_q))
    else $error("copy to A wrong");
  write_all_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (exec & ~pd & tgt == 2'h3 & ~c_sel)
    |=> (chan_a.code == $past(data)) && (chan_b.code == $past(data)))
    else $error("broadcast write wrong");
  copy_all_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (exec & ~pd & tgt == 2'h3 & c_sel)
    |=> (chan_a.code == $past(in_a_q)) && (chan_b.code == $past(in_b_q)) && $stable(in_a_q))
    else $error("simultaneous copy wrong");
  pd_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (exec & pd)
    |=> $stable(in_a_q) && $stable(in_b_q) && $stable(chan_a.code) && $stable(chan_b.code))
    else $error("power-down changed data");
  pd_target_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (exec & pd & tgt == ddac_pkg::PD_TGT_A)
    |=> $stable(chan_b.term) && (chan_a.term != ddac_pkg::DDAC_TERM_ACTIVE))
    else $error("power-down target wrong");
  pd_term_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (exec & pd & (tgt != ddac_pkg::PD_TGT_B) & (tsel == 2'h1))
    |=> chan_a.term == ddac_pkg::DDAC_TERM_1K)
    else $error("power-down termination wrong");
  zero_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n)
    |-> (chan_a.code == ddac_pkg::ZERO_SCALE) && (chan_b.code == ddac_pkg::ZERO_SCALE)
    && (in_a_q == ddac_pkg::ZERO_SCALE) && (in_b_q == ddac_pkg::ZERO_SCALE))
    else $error("reset did not clear to zero scale");
  // nothing runs before the sixteenth bit
  early_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (~chain_s & (cnt_q < ddac_pkg::FRAME_LEN - 5'h1))
    |=> $stable(chan_a) && $stable(chan_b) && $stable(in_a_q) && $stable(in_b_q))
    else $error("incomplete frame executed");
  late_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bit_take & ~chain_s & done_q)
    |=> $stable(chan_a) && $stable(chan_b) && $stable(in_a_q) && $stable(in_b_q))
    else $error("bits after the frame acted on");
  // chained frame runs the last bits
  chain_exec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    chain_end_s ##0 ({c_hi, c_lo, c_sel, pd} == 4'hc)
    |=> (chan_a.code == $past(shift_q[11:0])) && (chan_b.code == $past(shift_q[11:0])))
    else $error("chained write wrong");
endmodule // ddac_decoder

//--- test/ddac_host_model.sv
// host serial controller model driving the converter frame pins
`timescale 1ns/100ps
module ddac_host_model (
  output logic      sclk,
  output logic      sync_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  logic [63:0] rx_bits; // chained data out, one sample a bit

  // idle pins: clock parked high, frame closed
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    serial_in = 1'b0;
    rx_bits = '0;
  end

  task automatic send(input logic [31:0] word, input int nbits);
    sync_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in = word[i];
      #80 rx_bits = {rx_bits[62:0], serial_out};
      sclk = 1'b0;
      #80 sclk = 1'b1;
    end
    // last fall is seen before sync rises; one sample per bit only
    #80 sync_n = 1'b1;
    serial_in = ~serial_in; // released line shows no stale bit
  endtask
endmodule // ddac_host_model

//--- test/ddac_decoder_test.sv
// self-checking bench for the dual converter command decoder
`timescale 1ns/100ps
module ddac_decoder_test;
  localparam ddac_pkg::ddac_term_t T_ACT = ddac_pkg::DDAC_TERM_ACTIVE;
  localparam ddac_pkg::ddac_term_t T_FLT = ddac_pkg::DDAC_TERM_FLOAT;
  localparam ddac_pkg::ddac_term_t T_1K  = ddac_pkg::DDAC_TERM_1K;
  localparam ddac_pkg::ddac_term_t T_HK  = ddac_pkg::DDAC_TERM_100K;
  logic                 sys_clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 async_clear_n = 1'b1;
  logic                 chain_enable = 1'b0;
  wire logic            sclk, sync_n, serial_in, serial_out, serial_out_oe;
  wire logic            sdo_line;
  ddac_pkg::ddac_chan_t chan_a;
  ddac_pkg::ddac_chan_t chan_b;
  int                   err_count = 0;
  int                   comparisons = 0;
  int                   cycles = 0;

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  ddac_decoder i_ddac_decoder (.sys_clk(sys_clk), .resetn(resetn),
    .async_clear_n(async_clear_n), .sclk(sclk), .sync_n(sync_n), .serial_in(serial_in),
    .chain_enable(chain_enable), .chan_a(chan_a), .chan_b(chan_b),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  // released data out floats to its pull-up
  assign sdo_line = serial_out_oe ? serial_out : 1'b1;
  ddac_host_model i_ddac_host_model (.sclk(sclk), .sync_n(sync_n),
    .serial_in(serial_in), .serial_out(sdo_line));

  // verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // compare of two 16-bit words
  task automatic chk_word(input logic [15:0] act, input logic [15:0] exp);
    comparisons++;
    if (act !== exp) begin
      err_count++;
      $display("MISMATCH %0t word %h expected %h", $time, act, exp);
    end
  endtask

  // compare of both channel outputs
  task automatic chk_ab(input logic [11:0] ac, input ddac_pkg::ddac_term_t at,
                        input logic [11:0] bc, input ddac_pkg::ddac_term_t bt);
    comparisons++;
    if ({chan_a, chan_b} !== {ac, at, bc, bt}) begin
      err_count++;
      $display("MISMATCH %0t chan %h %h expected %h %h", $time, chan_a, chan_b,
               {ac, at}, {bc, bt});
    end
  endtask

  // one full frame, then time to execute
  task automatic wr(input logic [15:0] word);
    i_ddac_host_model.send({16'h0000, word}, 16);
    repeat (12) @(negedge sys_clk);
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      $display("MISMATCH %0t timeout", $time);
      wrap_up();
    end
  end

  // main sequence
  initial begin
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk_ab(12'h000, T_ACT, 12'h000, T_ACT);
    chk_word({15'h0000, serial_out_oe}, 16'h0000);
    $display("test reset done");
    wr(16'h0123);
    chk_ab(12'h000, T_ACT, 12'h000, T_ACT);
    wr(16'h2456);
    chk_ab(12'h000, T_ACT, 12'h000, T_ACT);
    wr(16'he000);
    chk_ab(12'h123, T_ACT, 12'h456, T_ACT);
    wr(16'h4111);
    chk_ab(12'h111, T_ACT, 12'h456, T_ACT);
    wr(16'h2222);
    wr(16'h6333);
    chk_ab(12'h333, T_ACT, 12'h222, T_ACT);
    wr(16'h8444);
    chk_ab(12'h333, T_ACT, 12'h444, T_ACT);
    wr(16'h0555);
    wr(16'ha666);
    chk_ab(12'h555, T_ACT, 12'h666, T_ACT);
    wr(16'hcfff);
    chk_ab(12'hfff, T_ACT, 12'hfff, T_ACT);
    $display("test normal codes done");
    wr(16'h1400);
    chk_ab(12'hfff, T_1K, 12'hfff, T_1K);
    wr(16'h5bff);
    chk_ab(12'hfff, T_HK, 12'hfff, T_1K);
    wr(16'h9c00);
    chk_ab(12'hfff, T_HK, 12'hfff, T_FLT);
    wr(16'hf800);
    chk_ab(12'hfff, T_HK, 12'hfff, T_HK);
    wr(16'h7000);
    chk_ab(12'hfff, T_FLT, 12'hfff, T_HK);
    $display("test power down done");
    i_ddac_host_model.send(32'h00004abc, 15);
    repeat (12) @(negedge sys_clk);
    chk_ab(12'hfff, T_FLT, 12'hfff, T_HK);
    i_ddac_host_model.send(32'h0004123f, 20);
    repeat (12) @(negedge sys_clk);
    chk_ab(12'h123, T_ACT, 12'hfff, T_HK);
    $display("test frame length done");
    chain_enable = 1'b1;
    repeat (4) @(negedge sys_clk);
    i_ddac_host_model.send(32'hc123c9ab, 32);
    repeat (12) @(negedge sys_clk);
    chk_ab(12'h9ab, T_ACT, 12'h9ab, T_ACT);
    chk_word(i_ddac_host_model.rx_bits[15:0], 16'hc123);
    chain_enable = 1'b0;
    $display("test chain done");
    async_clear_n = 1'b0;
    @(negedge sys_clk);
    chk_ab(12'h000, T_ACT, 12'h000, T_ACT);
    async_clear_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    wr(16'hc00f);
    chk_ab(12'h00f, T_ACT, 12'h00f, T_ACT);
    $display("test clear done");
    wrap_up();
  end
endmodule // ddac_decoder_test
